/* File: pkg/pmrb_cfg.svh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * power monitor register bank. Assumes a 100 MHz device clock.
 */
`ifndef PMRB_CFG_SVH
`define PMRB_CFG_SVH
// ***********************************************
// pointer offsets
// ***********************************************
`define PMRB_PTR_CFG   8'h00
`define PMRB_PTR_SHUNT 8'h01
`define PMRB_PTR_BUS   8'h02
`define PMRB_PTR_PWR   8'h03
`define PMRB_PTR_CUR   8'h04
`define PMRB_PTR_CAL   8'h05
`define PMRB_PTR_MASK  8'h06
`define PMRB_PTR_LIM   8'h07
// ***********************************************
// reset values and field positions
// ***********************************************
`define PMRB_CFG_RST      16'h4127
`define PMRB_ZERO_RST     16'h0000
`define PMRB_CFG_SRST_BIT 15
`define PMRB_CFG_KEEP     16'hF000
`define PMRB_AVG_LSB      9
`define PMRB_BUS_CONV_TIME_FIELD_LSB  6
`define PMRB_SHUNT_CONV_TIME_FIELD_LSB   3
`define PMRB_MASK_WR      16'hFC03
`define PMRB_CVRF_BIT     3
`define PMRB_BUS_SIGN_BIT 15
// ***********************************************
// conversion times in microseconds, clock period
// ***********************************************
`define PMRB_CLK_NS 10
`define PMRB_CT0_US 140
`define PMRB_CT1_US 204
`define PMRB_CT2_US 332
`define PMRB_CT3_US 588
`define PMRB_CT4_US 1100
`define PMRB_CT5_US 2116
`define PMRB_CT6_US 4156
`define PMRB_CT7_US 8244
`define PMRB_CUR_SHIFT 11
`define PMRB_PWR_SHIFT 12
`endif

/* File: pkg/pmrb_pkg.sv */
/*
 * Types and shared decode of the power monitor register bank.
 * Assumes pmrb_cfg.svh is on the include path.
 */
`include "pmrb_cfg.svh"
package pmrb_pkg;
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_PTR  = 2'b01,
		W_MSB  = 2'b10,
		W_LSB  = 2'b11
	} pmrb_wr_state_type;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_SHUNT = 2'b01,
		S_BUS   = 2'b10
	} pmrb_seq_state_type;

	// averaging code to log2 of the sample count (1,4,16..1024)
	function automatic logic [3:0] pmrb_avg_shift(input logic [2:0] code);
		case (code)
			3'h0: pmrb_avg_shift = 4'h0;
			3'h1: pmrb_avg_shift = 4'h2;
			3'h2: pmrb_avg_shift = 4'h4;
			3'h3: pmrb_avg_shift = 4'h6;
			3'h4: pmrb_avg_shift = 4'h7;
			3'h5: pmrb_avg_shift = 4'h8;
			3'h6: pmrb_avg_shift = 4'h9;
			default: pmrb_avg_shift = 4'hA;
		endcase
	endfunction : pmrb_avg_shift
endpackage : pmrb_pkg

/* File: pkg/pmrb_conv_if.sv */
/*
 * Link between the register bank and its conversion sequencer.
 * Assumes both ends run on the same device clock.
 */
`timescale 1ns/1ns
interface pmrb_conv_if;
	logic [2:0] mode;
	logic [2:0] bus_conv_time_field;
	logic [2:0] shunt_conv_time_field;
	logic [2:0] averaging_count_field;
	logic       clr;
	logic       restart;
	logic       hold;
	logic       shunt_take;
	logic       bus_take;
	logic       set_done;
	logic       busy;
	modport bank (output mode, bus_conv_time_field, shunt_conv_time_field, averaging_count_field, clr, restart, hold,
		input shunt_take, bus_take, set_done, busy);
	modport seq (input mode, bus_conv_time_field, shunt_conv_time_field, averaging_count_field, clr, restart, hold,
		output shunt_take, bus_take, set_done, busy);
endinterface : pmrb_conv_if

/* File: design/pmrb_conv_seq.sv */
/*
 * Conversion sequencer: paces shunt and bus conversions and averaging.
 * Assumes restart is a one-cycle pulse and the bank owns the results.
 */
`timescale 1ns/1ns
module pmrb_conv_seq
	import pmrb_pkg::*;
#(
	parameter int unsigned CT_CYC [8] = '{8{32'd14000}}
) (
	input  wire logic CLK_I,
	input  wire logic RST_N_I,
	pmrb_conv_if.seq  cv
);
	pmrb_seq_state_type st_r;
	logic [19:0]        tmr_r;
	logic [10:0]        nsmp_r;
	logic               done_r;
	logic [19:0]        lim;
	logic               tick;
	logic               last_smp;

	// conversion length of the phase in progress, longest is 824400
	assign lim = (st_r == S_BUS) ? 20'(CT_CYC[cv.bus_conv_time_field] - 1)
		: 20'(CT_CYC[cv.shunt_conv_time_field] - 1);
	assign tick = (st_r != S_IDLE) && !cv.hold && (tmr_r == lim);
	assign last_smp = ((nsmp_r + 11'h001) >> pmrb_avg_shift(cv.averaging_count_field)) != 11'h000;
	assign cv.shunt_take = tick && (st_r == S_SHUNT);
	assign cv.bus_take = tick && (st_r == S_BUS);
	assign cv.set_done = done_r;
	assign cv.busy = (st_r != S_IDLE);

	// phase machine; power-down codes never leave idle
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || cv.clr) begin
			st_r <= S_IDLE;
			tmr_r <= 20'h00000;
			nsmp_r <= 11'h000;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (cv.restart) begin
				tmr_r <= 20'h00000;
				nsmp_r <= 11'h000;
				case (cv.mode[1:0])
					2'b00: st_r <= S_IDLE;
					2'b10: st_r <= S_BUS;
					default: st_r <= S_SHUNT;
				endcase
			end else if (cv.hold || st_r == S_IDLE) begin
				tmr_r <= tmr_r; // a config write freezes the timer
			end else if (!tick) begin
				tmr_r <= tmr_r + 20'h00001;
			end else begin
				tmr_r <= 20'h00000;
				if (st_r == S_SHUNT && cv.mode[1]) begin
					st_r <= S_BUS;
				end else if (!last_smp) begin
					nsmp_r <= nsmp_r + 11'h001;
					st_r <= cv.mode[0] ? S_SHUNT : S_BUS;
				end else begin
					nsmp_r <= 11'h000;
					done_r <= 1'b1;
					// triggered modes run one set, continuous ones repeat
					if (cv.mode[2]) begin
						st_r <= cv.mode[0] ? S_SHUNT : S_BUS;
					end else begin
						st_r <= S_IDLE;
					end
				end
			end
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	property p_hold_freeze;
		@(posedge CLK_I) disable iff (!RST_N_I)
		cv.hold && !cv.restart && !cv.clr |=> $stable(tmr_r) && !cv.shunt_take;
	endproperty
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("conversion advanced during config write");

	property p_pdown_idle;
		@(posedge CLK_I) disable iff (!RST_N_I)
		cv.restart && !cv.clr && cv.mode[1:0] == 2'b00 |=> st_r == S_IDLE;
	endproperty
	a_pdown_idle: assert property (p_pdown_idle)
		else $error("power-down mode started a conversion");

	c_set_done: cover property (@(posedge CLK_I) disable iff (!RST_N_I) cv.set_done);
endmodule : pmrb_conv_seq

/* File: design/pmrb_power_monitor_regs.sv */
/*
 * Register bank of a current, voltage and power monitor, reached as
 * bytes from a two-wire serial slave engine (engine not included).
 * Assumes the engine and the ADC front end run on CLK_I.
 */
`timescale 1ns/1ns
module pmrb_power_monitor_regs
	import pmrb_pkg::*;
#(
	parameter int unsigned CT_CYC [8] = '{
		`PMRB_CT0_US * 1000 / `PMRB_CLK_NS, `PMRB_CT1_US * 1000 / `PMRB_CLK_NS,
		`PMRB_CT2_US * 1000 / `PMRB_CLK_NS, `PMRB_CT3_US * 1000 / `PMRB_CLK_NS,
		`PMRB_CT4_US * 1000 / `PMRB_CLK_NS, `PMRB_CT5_US * 1000 / `PMRB_CLK_NS,
		`PMRB_CT6_US * 1000 / `PMRB_CLK_NS, `PMRB_CT7_US * 1000 / `PMRB_CLK_NS},
	parameter int unsigned CUR_SHIFT = `PMRB_CUR_SHIFT,
	parameter int unsigned PWR_SHIFT = `PMRB_PWR_SHIFT
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        WR_START_I,
	input  wire logic        WR_BYTE_VLD_I,
	input  wire logic [7:0]  WR_BYTE_I,
	input  wire logic        RD_BYTE_REQ_I,
	output logic      [7:0]  RD_BYTE_O,
	input  wire logic        FRAME_END_I,
	input  wire logic [15:0] SHUNT_ADC_I,
	input  wire logic [15:0] BUS_ADC_I,
	output logic             CONV_BUSY_O,
	output logic             CONV_READY_O
);
	pmrb_conv_if cv ();

	pmrb_wr_state_type wst_r;
	logic [7:0]         ptr_r;
	logic [7:0]         msb_r;
	logic [15:0]        cfg_r;
	logic [15:0]        shunt_r;
	logic [15:0]        bus_r;
	logic [15:0]        pwr_r;
	logic [15:0]        cur_r;
	logic [15:0]        cal_r;
	logic [15:0]        mask_r;
	logic [15:0]        lim_r;
	logic [25:0]        acc_sh_r;
	logic [25:0]        acc_bus_r;
	logic               calc_r;
	logic               start_r;
	logic               rd_ph_r;
	logic [7:0]         rd_lsb_r;
	logic               commit;
	logic [15:0]        wdata;
	logic               soft_rst;
	logic               bank_rst;
	logic [15:0]        reg_rd;
	logic [31:0]        cur_full;
	logic [31:0]        pwr_full;
	logic [3:0]         ash;

	// ***********************************************
	// byte assembly from the serial engine
	// ***********************************************
	assign commit = WR_BYTE_VLD_I && (wst_r == W_LSB);
	assign wdata = {msb_r, WR_BYTE_I};
	assign soft_rst = commit && ptr_r == `PMRB_PTR_CFG && wdata[`PMRB_CFG_SRST_BIT];
	assign bank_rst = !RST_N_I || soft_rst;

	// write frame: address ack, pointer byte, then MSB/LSB pairs
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			wst_r <= W_IDLE;
		end else if (WR_START_I) begin
			wst_r <= W_PTR;
		end else if (FRAME_END_I) begin
			wst_r <= W_IDLE;
		end else if (WR_BYTE_VLD_I) begin
			case (wst_r)
				W_PTR: wst_r <= W_MSB;
				W_MSB: wst_r <= W_LSB;
				W_LSB: wst_r <= W_MSB;
				default: wst_r <= W_IDLE;
			endcase
		end
	end

	// pointer changes only on the pointer byte, never on a read
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			ptr_r <= `PMRB_PTR_CFG;
		end else if (WR_BYTE_VLD_I && wst_r == W_PTR && !WR_START_I) begin
			ptr_r <= WR_BYTE_I;
		end
	end

	// high byte is parked until its partner arrives
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			msb_r <= 8'h00;
		end else if (WR_BYTE_VLD_I && wst_r == W_MSB) begin
			msb_r <= WR_BYTE_I;
		end
	end

	// ***********************************************
	// writable registers
	// ***********************************************
	// reserved bits keep their reset value; bit 15 is never stored
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			cfg_r <= `PMRB_CFG_RST;
		end else if (commit && ptr_r == `PMRB_PTR_CFG) begin
			cfg_r <= (wdata & ~`PMRB_CFG_KEEP) | (cfg_r & `PMRB_CFG_KEEP);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			cal_r <= `PMRB_ZERO_RST;
			lim_r <= `PMRB_ZERO_RST;
		end else if (commit && ptr_r == `PMRB_PTR_CAL) begin
			cal_r <= wdata;
		end else if (commit && ptr_r == `PMRB_PTR_LIM) begin
			lim_r <= wdata;
		end
	end

	// ready flag: set by a finished result, cleared by reading this
	// register; a set in the same cycle wins so no result is missed
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			mask_r <= `PMRB_ZERO_RST;
		end else begin
			if (commit && ptr_r == `PMRB_PTR_MASK) begin
				mask_r <= (wdata & `PMRB_MASK_WR) | (mask_r & ~`PMRB_MASK_WR);
			end
			if (calc_r) begin
				mask_r[`PMRB_CVRF_BIT] <= 1'b1;
			end else if (RD_BYTE_REQ_I && !rd_ph_r && ptr_r == `PMRB_PTR_MASK) begin
				mask_r[`PMRB_CVRF_BIT] <= 1'b0;
			end
		end
	end

	// ***********************************************
	// conversion control
	// ***********************************************
	// restart after reset and after every completed config write
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			start_r <= 1'b1;
		end else begin
			start_r <= commit && ptr_r == `PMRB_PTR_CFG;
		end
	end

	assign cv.mode = cfg_r[2:0];
	assign cv.bus_conv_time_field = cfg_r[`PMRB_BUS_CONV_TIME_FIELD_LSB +: 3];
	assign cv.shunt_conv_time_field = cfg_r[`PMRB_SHUNT_CONV_TIME_FIELD_LSB +: 3];
	assign cv.averaging_count_field = cfg_r[`PMRB_AVG_LSB +: 3];
	assign cv.clr = soft_rst;
	assign cv.restart = start_r;
	assign cv.hold = (wst_r == W_LSB) && ptr_r == `PMRB_PTR_CFG;
	assign CONV_BUSY_O = cv.busy;
	assign CONV_READY_O = mask_r[`PMRB_CVRF_BIT];

	pmrb_conv_seq #(
		.CT_CYC (CT_CYC)
	) u_seq (
		.CLK_I   (CLK_I),
		.RST_N_I (RST_N_I),
		.cv      (cv)
	);

	// ***********************************************
	// averaging and results
	// ***********************************************
	assign ash = pmrb_avg_shift(cfg_r[`PMRB_AVG_LSB +: 3]);

	// signed shunt sum, unsigned bus sum; counts are powers of two so the mean is a shift
	always_ff @(posedge CLK_I) begin
		if (bank_rst || start_r || cv.set_done) begin
			acc_sh_r <= 26'h0000000;
			acc_bus_r <= 26'h0000000;
		end else begin
			if (cv.shunt_take) begin
				acc_sh_r <= acc_sh_r + 26'({{10{SHUNT_ADC_I[15]}}, SHUNT_ADC_I});
			end
			if (cv.bus_take) begin
				acc_bus_r <= acc_bus_r + 26'({10'h000, BUS_ADC_I});
			end
		end
	end

	// results only change at set end; writes to them are acked, dropped
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			shunt_r <= `PMRB_ZERO_RST;
			bus_r <= `PMRB_ZERO_RST;
		end else if (cv.set_done) begin
			if (cfg_r[0]) begin
				shunt_r <= 16'($signed(acc_sh_r) >>> ash);
			end
			if (cfg_r[1]) begin
				bus_r <= 16'(acc_bus_r >> ash) & ~(16'h0001 << `PMRB_BUS_SIGN_BIT);
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			calc_r <= 1'b0;
		end else begin
			calc_r <= cv.set_done;
		end
	end

	assign cur_full = 32'($signed(shunt_r) * $signed({1'b0, cal_r}));
	assign pwr_full = 32'($signed(cur_r) * $signed({1'b0, bus_r}));

	// derived values; a zero calibration pins both at zero
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			cur_r <= `PMRB_ZERO_RST;
			pwr_r <= `PMRB_ZERO_RST;
		end else if (cal_r == `PMRB_ZERO_RST) begin
			cur_r <= `PMRB_ZERO_RST;
			pwr_r <= `PMRB_ZERO_RST;
		end else if (calc_r) begin
			cur_r <= 16'($signed(cur_full) >>> CUR_SHIFT);
			pwr_r <= 16'($signed(pwr_full) >>> PWR_SHIFT);
		end
	end

	// ***********************************************
	// read path
	// ***********************************************
	// pointer decode; an unmapped pointer reads zero
	always_comb begin
		if (ptr_r == `PMRB_PTR_CFG) begin
			reg_rd = cfg_r;
		end else if (ptr_r == `PMRB_PTR_SHUNT) begin
			reg_rd = shunt_r;
		end else if (ptr_r == `PMRB_PTR_BUS) begin
			reg_rd = bus_r;
		end else if (ptr_r == `PMRB_PTR_PWR) begin
			reg_rd = pwr_r;
		end else if (ptr_r == `PMRB_PTR_CUR) begin
			reg_rd = cur_r;
		end else if (ptr_r == `PMRB_PTR_CAL) begin
			reg_rd = cal_r;
		end else if (ptr_r == `PMRB_PTR_MASK) begin
			reg_rd = mask_r;
		end else if (ptr_r == `PMRB_PTR_LIM) begin
			reg_rd = lim_r;
		end else begin
			reg_rd = `PMRB_ZERO_RST;
		end
	end

	// low byte is snapshot with the high one so a pair never tears
	always_ff @(posedge CLK_I) begin
		if (bank_rst) begin
			rd_ph_r <= 1'b0;
			rd_lsb_r <= 8'h00;
			RD_BYTE_O <= 8'h00;
		end else if (WR_START_I || FRAME_END_I) begin
			rd_ph_r <= 1'b0;
		end else if (RD_BYTE_REQ_I) begin
			rd_ph_r <= !rd_ph_r;
			if (!rd_ph_r) begin
				RD_BYTE_O <= reg_rd[15:8];
				rd_lsb_r <= reg_rd[7:0];
			end else begin
				RD_BYTE_O <= rd_lsb_r;
			end
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	property p_por_cfg;
		@(posedge CLK_I) !RST_N_I |=> cfg_r == 16'h4127 && ptr_r == 8'h00;
	endproperty
	a_por_cfg: assert property (p_por_cfg)
		else $error("config not at power-on value");

	property p_cal_zero;
		@(posedge CLK_I) disable iff (!RST_N_I)
		cal_r == 16'h0000 ##1 cal_r == 16'h0000 |-> cur_r == 16'h0000 && pwr_r == 16'h0000;
	endproperty
	a_cal_zero: assert property (p_cal_zero)
		else $error("nonzero current or power with zero calibration");

	property p_cfg_read;
		@(posedge CLK_I) disable iff (!RST_N_I)
		RD_BYTE_REQ_I && !WR_BYTE_VLD_I && ptr_r == 8'h00 |=> $stable(cfg_r) && !start_r;
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("config read disturbed settings");

	property p_cfg_restart;
		@(posedge CLK_I) disable iff (!RST_N_I)
		commit && ptr_r == 8'h00 && !WR_BYTE_I[7] && !msb_r[7] |=> start_r;
	endproperty
	a_cfg_restart: assert property (p_cfg_restart)
		else $error("config write did not restart conversion");

	property p_soft_rst;
		@(posedge CLK_I) disable iff (!RST_N_I)
		soft_rst |=> cfg_r == 16'h4127 && cal_r == 16'h0000 && lim_r == 16'h0000
			&& !cfg_r[15];
	endproperty
	a_soft_rst: assert property (p_soft_rst)
		else $error("soft reset left a register changed");

	property p_ptr_load;
		@(posedge CLK_I) disable iff (!RST_N_I)
		WR_BYTE_VLD_I && wst_r == W_PTR && !WR_START_I |=> ptr_r == $past(WR_BYTE_I);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("pointer byte not loaded");

	property p_ptr_keep;
		@(posedge CLK_I) disable iff (!RST_N_I)
		RD_BYTE_REQ_I && !WR_BYTE_VLD_I |=> $stable(ptr_r);
	endproperty
	a_ptr_keep: assert property (p_ptr_keep)
		else $error("pointer moved on a read");

	property p_msb_first;
		@(posedge CLK_I) disable iff (!RST_N_I)
		RD_BYTE_REQ_I && !rd_ph_r && !WR_START_I && !FRAME_END_I && ptr_r == 8'h05
		|=> RD_BYTE_O == $past(cal_r[15:8])
			and (RD_BYTE_REQ_I && !WR_START_I && !FRAME_END_I
			|=> RD_BYTE_O == $past(cal_r[7:0], 2));
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("register bytes out of order");

	property p_ro_write;
		@(posedge CLK_I) disable iff (!RST_N_I)
		commit && ptr_r == 8'h03 && !calc_r && cal_r != 16'h0000 |=> $stable(pwr_r);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write changed a result register");

	c_cfg_write: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		commit && ptr_r == 8'h00);
	c_soft_rst: cover property (@(posedge CLK_I) disable iff (!RST_N_I) soft_rst);
	c_ready_clr: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
		CONV_READY_O ##1 !CONV_READY_O);
endmodule : pmrb_power_monitor_regs

/* File: tb/pmrb_host_model.sv */
/*
 * Byte-level model of the two-wire host as seen through the slave engine.
 * Assumes the bank samples every strobe on the rising edge of clk_i.
 */
`timescale 1ns/1ns
module pmrb_host_model (
	input  wire logic       clk_i,
	output logic            wr_start_o,
	output logic            wr_vld_o,
	output logic      [7:0] wr_byte_o,
	output logic            rd_req_o,
	output logic            frame_end_o,
	input  wire logic [7:0] rd_byte_i
);
	// ***********************************************
	// idle levels
	// ***********************************************
	// strobes only ever change on the falling edge
	initial begin
		wr_start_o  = 1'b0;
		wr_vld_o    = 1'b0;
		wr_byte_o   = 8'h00;
		rd_req_o    = 1'b0;
		frame_end_o = 1'b0;
	end

	// ***********************************************
	// frames
	// ***********************************************
	// pointer byte right after the address, then MSB/LSB pairs
	task automatic wr_frame(input logic [7:0] q[$]);
		@(negedge clk_i);
		wr_start_o = 1'b1;
		foreach (q[i]) begin
			@(negedge clk_i);
			wr_start_o = 1'b0;
			wr_vld_o   = 1'b1;
			wr_byte_o  = q[i];
		end
		@(negedge clk_i);
		wr_vld_o    = 1'b0;
		wr_byte_o   = ~wr_byte_o; // a released lane must not look like valid data
		frame_end_o = 1'b1;
		@(negedge clk_i);
		frame_end_o = 1'b0;
	endtask : wr_frame

	// two requests back to back: MSB then LSB of one snapshot
	task automatic rd_word(output logic [15:0] w);
		@(negedge clk_i);
		rd_req_o = 1'b1;
		@(negedge clk_i);
		w[15:8] = rd_byte_i;
		@(negedge clk_i);
		rd_req_o    = 1'b0;
		w[7:0]      = rd_byte_i;
		frame_end_o = 1'b1;
		@(negedge clk_i);
		frame_end_o = 1'b0;
	endtask : rd_word
endmodule : pmrb_host_model

/* File: tb/pmrb_power_monitor_regs_test.sv */
/*
 * Self-checking bench of the power monitor register bank.
 * Assumes the host model stands in for the serial slave engine.
 */
`timescale 1ns/1ns
module pmrb_power_monitor_regs_test;
	import pmrb_pkg::*;
	// short conversion times keep the run small; spaced so codes are told apart
	localparam int unsigned CT_T [8] = '{20, 30, 40, 50, 60, 70, 80, 90};
	localparam int          NAVG [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
	logic        CLK_I = 1'b0;
	logic        RST_N_I = 1'b0;
	logic        wr_start, wr_vld, rd_req, frame_end, busy, ready;
	logic [7:0]  wr_byte, rd_byte;
	logic [15:0] shunt_adc = 16'h0000;
	logic [15:0] bus_adc = 16'h0000;
	logic [15:0] w;
	int          err_total = 0;
	int          n_tests = 0;
	int          d;

	// ***********************************************
	// clock, design and host
	// ***********************************************
	// free-running 100 MHz clock
	always #5 CLK_I = ~CLK_I;

	pmrb_power_monitor_regs #(.CT_CYC(CT_T)) dut_u (
		.CLK_I(CLK_I), .RST_N_I(RST_N_I), .WR_START_I(wr_start), .WR_BYTE_VLD_I(wr_vld),
		.WR_BYTE_I(wr_byte), .RD_BYTE_REQ_I(rd_req), .RD_BYTE_O(rd_byte),
		.FRAME_END_I(frame_end), .SHUNT_ADC_I(shunt_adc), .BUS_ADC_I(bus_adc),
		.CONV_BUSY_O(busy), .CONV_READY_O(ready));

	pmrb_host_model host_u (
		.clk_i(CLK_I), .wr_start_o(wr_start), .wr_vld_o(wr_vld), .wr_byte_o(wr_byte),
		.rd_req_o(rd_req), .frame_end_o(frame_end), .rd_byte_i(rd_byte));

	// ***********************************************
	// tasks
	// ***********************************************
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// word compare; care masks out the hardware ready flag where it may move
	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp,
		input logic [15:0] care);
		n_tests++;
		if ((got & care) !== (exp & care)) begin
			err_total++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_w

	task automatic chk_b(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_b

	task automatic wrreg(input logic [7:0] p, input logic [15:0] v);
		host_u.wr_frame('{p, v[15:8], v[7:0]});
	endtask : wrreg

	task automatic rdreg(input logic [7:0] p, output logic [15:0] v);
		host_u.wr_frame('{p});
		host_u.rd_word(v);
	endtask : rdreg

	// clear the ready flag by reading its register, then wait for a new result
	task automatic wait_ready();
		logic [15:0] t;
		rdreg(8'h06, t);
		d = 0;
		while (ready !== 1'b1 && d < 30000) begin
			@(negedge CLK_I);
			d++;
		end
		repeat (3) @(negedge CLK_I);
	endtask : wait_ready

	// idle the sequencer, clear the flag, then time one triggered result
	task automatic meas(input logic [15:0] cfg, input int lo, input int hi);
		wrreg(8'h00, 16'h4120);
		rdreg(8'h06, w);
		wrreg(8'h00, cfg);
		d = 0;
		while (ready !== 1'b1 && d < 30000) begin
			@(negedge CLK_I);
			d++;
		end
		chk_b(d >= lo && d <= hi, 1'b1);
	endtask : meas

	// ***********************************************
	// watchdog and tests
	// ***********************************************
	// the whole run is about 45k cycles; a hang is cut off at 90k
	initial begin
		repeat (90000) @(posedge CLK_I);
		err_total++;
		end_sim();
	end

	initial begin
		repeat (20) @(negedge CLK_I);
		RST_N_I = 1'b1;
		rdreg(8'h06, w);
		chk_w(w, 16'h0000, 16'hFFFF);
		for (int p = 0; p < 9; p++) begin
			rdreg(p[7:0], w);
			chk_w(w, (p == 0) ? 16'h4127 : 16'h0000, (p == 6) ? 16'hFFF7 : 16'hFFFF);
		end
		$display("reset values done");

		wrreg(8'h05, 16'h1234);
		wrreg(8'h07, 16'hA55A);
		wrreg(8'h06, 16'hFFFF);
		for (int p = 1; p < 5; p++) wrreg(p[7:0], 16'hFFFF);
		for (int p = 1; p < 5; p++) begin
			rdreg(p[7:0], w);
			chk_w(w, 16'h0000, 16'hFFFF);
		end
		rdreg(8'h06, w);
		chk_w(w, 16'hFC03, 16'hFFF7);
		rdreg(8'h07, w);
		chk_w(w, 16'hA55A, 16'hFFFF);
		host_u.rd_word(w);
		chk_w(w, 16'hA55A, 16'hFFFF);
		host_u.wr_frame('{8'h05, 8'hEE});
		rdreg(8'h05, w);
		chk_w(w, 16'h1234, 16'hFFFF);
		wrreg(8'h00, 16'h3127);
		rdreg(8'h00, w);
		chk_w(w, 16'h4127, 16'hFFFF);
		$display("access kinds done");

		// zero calibration hides current and power; then 0x100*0x800 scaled
		shunt_adc = 16'h0100;
		bus_adc = 16'h0800;
		wrreg(8'h05, 16'h0000);
		wait_ready();
		wait_ready();
		rdreg(8'h01, w);
		chk_w(w, 16'h0100, 16'hFFFF);
		rdreg(8'h02, w);
		chk_w(w, 16'h0800, 16'hFFFF);
		rdreg(8'h04, w);
		chk_w(w, 16'h0000, 16'hFFFF);
		rdreg(8'h03, w);
		chk_w(w, 16'h0000, 16'hFFFF);
		wrreg(8'h05, 16'h0800);
		wait_ready();
		wait_ready();
		rdreg(8'h04, w);
		chk_w(w, 16'h0100, 16'hFFFF);
		rdreg(8'h03, w);
		chk_w(w, 16'h0080, 16'hFFFF);
		$display("scaling done");

		// every mode code: running right after the write, then settled state
		for (int m = 0; m < 8; m++) begin
			wrreg(8'h00, 16'h4120 | m[15:0]);
			@(negedge CLK_I);
			chk_b(busy, m[1:0] != 2'b00);
			repeat (300) @(negedge CLK_I);
			rdreg(8'h00, w);
			chk_w(w, 16'h4120 | m[15:0], 16'hFFFF);
			chk_b(busy, m[2] && m[1:0] != 2'b00);
		end
		$display("modes done");

		for (int k = 0; k < 8; k++) begin
			meas(16'h4001 | 16'(k << 3) | 16'((7 - k) << 6), CT_T[k] - 2, CT_T[k] + 6);
			meas(16'h4002 | 16'(k << 6) | 16'((7 - k) << 3), CT_T[k] - 2, CT_T[k] + 6);
		end
		for (int a = 0; a < 8; a++)
			meas(16'h4001 | 16'(a << 9), NAVG[a] * 20 - 2, NAVG[a] * 21 + 6);
		$display("timing done");

		wrreg(8'h05, 16'h1234);
		wrreg(8'h00, 16'h8000);
		host_u.rd_word(w);
		chk_w(w, 16'h4127, 16'hFFFF);
		rdreg(8'h05, w);
		chk_w(w, 16'h0000, 16'hFFFF);
		$display("soft reset done");
		end_sim();
	end
endmodule : pmrb_power_monitor_regs_test
